// ===== design/sync_controller_command_outputs.sv
/*
 Command interpreter, status word, power-up parameter handling and
 analogue/direction output stage of the synchronizing controller.
 Assumes a serial framer delivers decoded access codes, an EEPROM
 agent answers load/store/erase requests, and the control loop
 supplies speed reference, error increments and master motion.
*/
`timescale 1ns/1ps
module sync_controller_command_outputs
  import sync_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // serial access port
  input  wire logic               reqValid,
  input  wire logic               reqWrite,
  input  wire logic [7:0]         reqCode,
  input  wire logic [15:0]        reqData,
  output logic                    rspValid,
  output logic                    rspErr,
  output logic [15:0]             rspData,
  // hardware control inputs
  input  wire ctl_t               ctlIn,
  // eeprom agent
  output logic                    eeReq,
  output ee_op_t                  eeOp,
  output param_t                  eeWrData,
  input  wire logic               eeDone,
  input  wire param_t             eeRdData,
  // control loop
  input  wire logic signed [11:0] speedRef,
  input  wire logic               errInc,
  input  wire logic               errDec,
  input  wire logic               masterMoving,
  input  wire logic               masterReverse,
  input  wire logic               outOfSync,
  input  wire logic               indexOk,
  input  wire logic [1:0]         auxOut,
  // effective commands and outputs
  output ctl_t                    cmdOut,
  output logic                    storeBusy,
  output logic signed [15:0]      errCount,
  output logic [11:0]             dacOut,
  output logic [3:0]              ctlOut,
  output logic                    ready
);

  function automatic logic inRange(input logic [7:0] code, input logic [15:0] d);
    case (code)
      CODE_FFSEL:    inRange = d[15:4] == 12'h0 && d[3:0] <= FF_MAX;
      CODE_DEADBAND: inRange = d[15:10] == 6'h0 && d[9:0] <= DB_MAX;
      CODE_OFFSET:   inRange = $signed(d) >= 16'(OFS_MIN) && $signed(d) <= 16'(OFS_MAX);
      default:       inRange = 1'b1;
    endcase
  endfunction

  function automatic logic [11:0] absVal(input logic signed [12:0] v);
    logic signed [12:0] a;
    a = v < 0 ? -v : v;
    absVal = a > DAC_MAX ? DAC_MAX[11:0] : a[11:0];
  endfunction

  // saturate a signed value into a 13-bit window, shared by correction and output
  function automatic logic signed [12:0] clamp13(input logic signed [15:0] v,
                                                 input logic signed [12:0] lo,
                                                 input logic signed [12:0] hi);
    if (v > 16'(hi)) begin
      clamp13 = hi;
    end else if (v < 16'(lo)) begin
      clamp13 = lo;
    end else begin
      clamp13 = v[12:0];
    end
  endfunction

  state_t             state_r, state_nxt;
  logic [15:0]        cmdWord_r, cmdWord_nxt;
  param_t             param_r, param_nxt;
  logic               rspValid_r, rspValid_nxt;
  logic               rspErr_r, rspErr_nxt;
  logic [15:0]        rspData_r, rspData_nxt;
  logic               eeReq_r, eeReq_nxt;
  ee_op_t             eeOp_r, eeOp_nxt;
  ctl_t               cmdOut_r, cmdOut_nxt;
  logic signed [15:0] err_r, err_nxt;
  logic [11:0]        dac_r, dac_nxt;
  logic [3:0]         ctlOut_r, ctlOut_nxt;
  logic               oneQ;
  logic signed [12:0] corr, sum, sat;
  logic [11:0]        mag;
  logic               fwd, rev;
  logic               effReset;
  logic               ready_r, ready_nxt;
  logic signed [15:0] dbWin;

  // interpreter, power-up sequence and parameters
  always_comb begin
    state_nxt    = state_r;
    cmdWord_nxt  = cmdWord_r;
    param_nxt    = param_r;
    rspValid_nxt = 1'b0;
    rspErr_nxt   = 1'b0;
    rspData_nxt  = rspData_r;
    eeReq_nxt    = eeReq_r;
    eeOp_nxt     = eeOp_r;

    case (state_r)
      ST_INIT: begin
        // all six inputs high at power-up: factory defaults
        if (&ctlIn) begin
          state_nxt = ST_ERASE;
          eeOp_nxt  = EE_ERASE;
          param_nxt = PARAM_DEFAULT;
        end else begin
          state_nxt = ST_LOAD;
          eeOp_nxt  = EE_LOAD;
        end
        eeReq_nxt = 1'b1;
      end
      ST_LOAD: begin
        if (eeDone) begin
          param_nxt = eeRdData;
          eeReq_nxt = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      ST_ERASE: begin
        if (eeDone) begin
          eeReq_nxt = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      ST_STORE: begin
        if (eeDone) begin
          eeReq_nxt             = 1'b0;
          cmdWord_nxt[BIT_STORE] = 1'b0;
          state_nxt             = ST_RUN;
        end
      end
      ST_RUN: begin
        // activation takes one cycle, then the bit drops
        cmdWord_nxt[BIT_ACTIVATE] = 1'b0;
        if (cmdWord_r[BIT_STORE]) begin
          eeOp_nxt  = EE_STORE;
          eeReq_nxt = 1'b1;
          state_nxt = ST_STORE;
        end
      end
      default: state_nxt = ST_INIT;
    endcase
    // registered so the ready port is a flop, in step with the state
    ready_nxt = state_nxt == ST_RUN;

    if (reqValid) begin
      rspValid_nxt = 1'b1;
      rspData_nxt  = 16'h0;
      // write requests during power-up or store are refused; reads are answered
      if (state_r != ST_RUN && reqWrite) begin
        rspErr_nxt = 1'b1;
      end else if (reqWrite && !inRange(reqCode, reqData)) begin
        rspErr_nxt = 1'b1;
      end else if (reqWrite) begin
        case (reqCode)
          CODE_RESET:    cmdWord_nxt[BIT_RESET]    = reqData[0];
          CODE_IDX_SLV:  cmdWord_nxt[BIT_IDX_SLV]  = reqData[0];
          CODE_IDX_MST:  cmdWord_nxt[BIT_IDX_MST]  = reqData[0];
          CODE_TRIM_M:   cmdWord_nxt[BIT_TRIM_M]   = reqData[0];
          CODE_TRIM_P:   cmdWord_nxt[BIT_TRIM_P]   = reqData[0];
          CODE_ACTIVATE: cmdWord_nxt[BIT_ACTIVATE] = reqData[0];
          CODE_STORE:    cmdWord_nxt[BIT_STORE]    = reqData[0];
          CODE_CMDWORD:  cmdWord_nxt = reqData & CMD_MASK;
          CODE_FFSEL:    param_nxt.ffSel = reqData[3:0];
          CODE_DEADBAND: param_nxt.deadBand = reqData[9:0];
          CODE_OFFSET:   param_nxt.offsetTrim = reqData[9:0];
          default:       rspErr_nxt = 1'b1;
        endcase
      end else begin
        case (reqCode)
          CODE_CMDWORD:  rspData_nxt = cmdWord_r & CMD_MASK;
          CODE_STATUS:   rspData_nxt = {12'h0, ctlOut_r};
          CODE_FFSEL:    rspData_nxt = {12'h0, param_r.ffSel};
          CODE_DEADBAND: rspData_nxt = {6'h0, param_r.deadBand};
          CODE_OFFSET:   rspData_nxt = {{6{param_r.offsetTrim[9]}}, param_r.offsetTrim};
          default:       rspErr_nxt = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r    <= ST_INIT;
      cmdWord_r  <= 16'h0;
      param_r    <= PARAM_DEFAULT;
      rspValid_r <= 1'b0;
      rspErr_r   <= 1'b0;
      rspData_r  <= 16'h0;
      eeReq_r    <= 1'b0;
      eeOp_r     <= EE_LOAD;
      ready_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cmdWord_r  <= cmdWord_nxt;
      param_r    <= param_nxt;
      rspValid_r <= rspValid_nxt;
      rspErr_r   <= rspErr_nxt;
      rspData_r  <= rspData_nxt;
      eeReq_r    <= eeReq_nxt;
      eeOp_r     <= eeOp_nxt;
      ready_r    <= ready_nxt;
    end
  end

  // effective commands, error memory and output stage
  assign effReset = cmdWord_r[BIT_RESET] | ctlIn.reset;
  assign oneQ = param_r.ffSel == FF_ONEQ || param_r.ffSel == FF_ONEQ_RECIP;
  // correction limited so a large error cannot swamp the reference
  assign corr = clamp13(err_r, CORR_MIN, CORR_MAX);
  // offset enters with inverted sign: negative trim lifts standstill
  assign sum = 13'(speedRef) + corr - 13'(param_r.offsetTrim);
  assign sat = clamp13(16'(sum), DAC_MIN, DAC_MAX);
  assign mag = absVal(sat);
  // widened as signed so a negative error is not read as a huge one
  assign dbWin = $signed({6'h0, param_r.deadBand});

  always_comb begin
    cmdOut_nxt.reset     = effReset;
    cmdOut_nxt.idxSlave  = cmdWord_r[BIT_IDX_SLV] | ctlIn.idxSlave;
    cmdOut_nxt.idxMaster = cmdWord_r[BIT_IDX_MST] | ctlIn.idxMaster;
    cmdOut_nxt.trimMinus = cmdWord_r[BIT_TRIM_M] | ctlIn.trimMinus;
    cmdOut_nxt.trimPlus  = cmdWord_r[BIT_TRIM_P] | ctlIn.trimPlus;
    cmdOut_nxt.activate  = cmdWord_r[BIT_ACTIVATE] | ctlIn.activate;

    err_nxt = err_r;
    if (effReset) begin
      err_nxt = 16'sh0;
    end else if (errInc && !errDec && err_r < ERR_SAT) begin
      err_nxt = err_r + 16'sd1;
    end else if (errDec && !errInc && err_r > -ERR_SAT) begin
      err_nxt = err_r - 16'sd1;
    end
    fwd = 1'b0;
    rev = 1'b0;
    dac_nxt = sat[11:0];
    if (oneQ) begin
      dac_nxt = mag;
      if (masterMoving) begin
        fwd = !masterReverse;
        rev = masterReverse;
      end else if (err_r > dbWin) begin
        fwd = 1'b1;
        dac_nxt = CREEP_REF;
      end else if (err_r < -dbWin) begin
        rev = 1'b1;
        dac_nxt = CREEP_REF;
      end else begin
        dac_nxt = 12'h0;
      end
      // below the dead band the drive is disabled
      if (masterMoving && mag < {2'b00, param_r.deadBand}) begin
        fwd = 1'b0;
        rev = 1'b0;
      end
    end
    if (oneQ) begin
      ctlOut_nxt = {rev, fwd, auxOut};
    end else begin
      ctlOut_nxt = {indexOk, outOfSync, auxOut};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmdOut_r <= '0;
      err_r    <= 16'sh0;
      dac_r    <= 12'h0;
      ctlOut_r <= 4'h0;
    end else begin
      cmdOut_r <= cmdOut_nxt;
      err_r    <= err_nxt;
      dac_r    <= dac_nxt;
      ctlOut_r <= ctlOut_nxt;
    end
  end

  assign rspValid  = rspValid_r;
  assign rspErr    = rspErr_r;
  assign rspData   = rspData_r;
  assign eeReq     = eeReq_r;
  assign eeOp      = eeOp_r;
  assign eeWrData  = param_r;
  assign cmdOut    = cmdOut_r;
  assign storeBusy = cmdWord_r[BIT_STORE];
  assign errCount  = err_r;
  assign dacOut    = dac_r;
  assign ctlOut    = ctlOut_r;
  assign ready     = ready_r;
endmodule

// ===== design/sync_ctrl_pkg.sv
/*
 Shared constants and types for the command and output logic of a
 positional synchronizing controller. Assumes one 250 MHz clock.
*/
package sync_ctrl_pkg;
  localparam logic [7:0]  CODE_RESET    = 8'd60;
  localparam logic [7:0]  CODE_IDX_SLV  = 8'd61;
  localparam logic [7:0]  CODE_IDX_MST  = 8'd62;
  localparam logic [7:0]  CODE_TRIM_M   = 8'd65;
  localparam logic [7:0]  CODE_TRIM_P   = 8'd66;
  localparam logic [7:0]  CODE_ACTIVATE = 8'd67;
  localparam logic [7:0]  CODE_STORE    = 8'd68;
  localparam logic [7:0]  CODE_STATUS   = 8'd85;
  localparam logic [7:0]  CODE_CMDWORD  = 8'd86;
  localparam logic [7:0]  CODE_OFFSET   = 8'd47;
  localparam logic [7:0]  CODE_DEADBAND = 8'd48;
  localparam logic [7:0]  CODE_FFSEL    = 8'd49;
  localparam int BIT_RESET = 7;
  localparam int BIT_IDX_SLV = 6;
  localparam int BIT_IDX_MST = 5;
  localparam int BIT_TRIM_M = 2;
  localparam int BIT_TRIM_P = 1;
  localparam int BIT_ACTIVATE = 12;
  localparam int BIT_STORE = 0;
  localparam logic [15:0] CMD_MASK      = 16'h10e7;
  localparam logic [3:0]  FF_ONEQ       = 4'h5;
  localparam logic [3:0]  FF_ONEQ_RECIP = 4'h6;
  localparam logic [3:0]  FF_MAX        = 4'h6;
  localparam logic [9:0]  DB_MAX        = 10'h190;
  localparam logic signed [9:0] OFS_MIN = -10'sd200;
  localparam logic signed [9:0] OFS_MAX = 10'sd200;
  localparam logic signed [15:0] ERR_SAT = 16'sd32000;
  localparam logic signed [12:0] CORR_MAX = 13'sd511;
  localparam logic signed [12:0] CORR_MIN = -13'sd512;
  localparam logic signed [12:0] DAC_MAX = 13'sd2047;
  localparam logic signed [12:0] DAC_MIN = -13'sd2048;
  localparam logic [11:0] CREEP_REF     = 12'h010;

  typedef struct packed {
    logic [3:0]        ffSel;
    logic [9:0]        deadBand;
    logic signed [9:0] offsetTrim;
  } param_t;
  localparam param_t PARAM_DEFAULT = '{ffSel: 4'h0, deadBand: 10'h0, offsetTrim: 10'sh0};

  typedef struct packed {
    logic reset;
    logic idxSlave;
    logic idxMaster;
    logic trimMinus;
    logic trimPlus;
    logic activate;
  } ctl_t;

  typedef enum logic [1:0] {EE_LOAD = 2'b00, EE_STORE = 2'b01, EE_ERASE = 2'b10} ee_op_t;
  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_ERASE = 3'b010,
    ST_RUN   = 3'b011,
    ST_STORE = 3'b100
  } state_t;
endpackage

// ===== verification/ee_store_model.sv
/*
 Behavioural EEPROM agent facing the block's parameter port.
 Assumes the block holds eeReq and eeOp until eeDone.
*/
`timescale 1ns/1ps
module ee_store_model
  import sync_ctrl_pkg::*;
#(
  parameter int     LAT  = 3,
  parameter param_t INIT = '{ffSel: 4'h0, deadBand: 10'h00f, offsetTrim: 10'sh0}
)(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   reset,
  // request side
  input  wire logic   eeReq,
  input  wire ee_op_t eeOp,
  input  wire param_t eeWrData,
  // answer side
  output logic        eeDone = 1'b0,
  output param_t      eeRdData = '0
);
  param_t mem = INIT;
  int     cnt = 0;
  logic   slow = 1'b0;
  // alternate prompt and slow answers
  always @(posedge clk_sys) begin
    eeDone <= 1'b0;
    eeRdData <= ~eeRdData;
    if (reset) begin
      cnt <= 0;
    end else if (eeReq && !eeDone) begin
      cnt <= cnt + 1;
      if (cnt >= (slow ? LAT : 0)) begin
        cnt <= 0;
        slow <= !slow;
        eeDone <= 1'b1;
        if (eeOp == EE_LOAD) eeRdData <= mem;
        if (eeOp == EE_STORE) mem <= eeWrData;
        if (eeOp == EE_ERASE) mem <= PARAM_DEFAULT;
      end
    end
  end
endmodule

// ===== verification/sync_controller_command_outputs_tb.sv
/*
 Self-checking bench: power-up, serial commands, status, one-quadrant outputs.
 Assumes the EEPROM model answers every request.
*/
`timescale 1ns/1ps
module sync_controller_command_outputs_tb
  import sync_ctrl_pkg::*;
;
  logic               clk_sys, reset, reqValid, reqWrite, rspValid, rspErr, eeReq, eeDone;
  logic               errInc, errDec, masterMoving, masterReverse, outOfSync, indexOk;
  logic               storeBusy, ready;
  logic [7:0]         reqCode;
  logic [15:0]        reqData, rspData, rd;
  logic [1:0]         auxOut;
  logic [3:0]         ctlOut;
  logic [11:0]        dacOut;
  logic signed [11:0] speedRef;
  logic signed [15:0] errCount;
  ctl_t               ctlIn, cmdOut;
  ee_op_t             eeOp;
  param_t             eeWrData, eeRdData;
  int                 err_total = 0, n_tests = 0, cyc = 0;

  sync_controller_command_outputs i_dut (
    .clk_sys, .reset, .reqValid, .reqWrite, .reqCode, .reqData, .rspValid, .rspErr,
    .rspData, .ctlIn, .eeReq, .eeOp, .eeWrData, .eeDone, .eeRdData, .speedRef, .errInc,
    .errDec, .masterMoving, .masterReverse, .outOfSync, .indexOk, .auxOut, .cmdOut,
    .storeBusy, .errCount, .dacOut, .ctlOut, .ready
  );
  ee_store_model i_ee (.clk_sys, .reset, .eeReq, .eeOp, .eeWrData, .eeDone, .eeRdData);

  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // answer is registered, so it is looked at one negedge after the strobe
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic e);
    @(negedge clk_sys);
    reqValid = 1;
    reqWrite = w;
    reqCode = c;
    reqData = d;
    @(negedge clk_sys);
    reqValid = 0;
    chk(rspValid, 1'b1);
    e = rspErr;
    rd = rspData;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ee);
    logic e;
    xfer(1'b1, c, d, e);
    chk(e, ee);
  endtask
  task automatic rdx(input logic [7:0] c);
    logic e;
    xfer(1'b0, c, 16'h0000, e);
    chk(e, 1'b0);
  endtask
  task automatic t_boot(input ee_op_t op, input logic [15:0] db);
    reset = 1;
    tick(2);
    reset = 0;
    for (int i = 0; i < 20 && !eeReq; i++) tick(1);
    chk(eeOp, op);
    for (int i = 0; i < 20 && !ready; i++) tick(1);
    chk(ready, 1'b1);
    rdx(CODE_DEADBAND);
    chk(rd, db);
  endtask
  task automatic t_cmd;
    logic [7:0] codes [5] = '{CODE_RESET, CODE_IDX_SLV, CODE_IDX_MST, CODE_TRIM_M, CODE_TRIM_P};
    int         bits [5] = '{BIT_RESET, BIT_IDX_SLV, BIT_IDX_MST, BIT_TRIM_M, BIT_TRIM_P};
    for (int i = 0; i < 5; i++) begin
      wr(codes[i], 16'h0001, 1'b0);
      rdx(CODE_CMDWORD);
      chk(rd, 16'h0001 << bits[i]);
      wr(codes[i], 16'h0000, 1'b0);
    end
    wr(CODE_CMDWORD, 16'hefe6, 1'b0);
    rdx(CODE_CMDWORD);
    chk(rd, 16'h00e6);
    chk(cmdOut.reset, 1'b1);
    wr(CODE_CMDWORD, 16'h1000, 1'b0);
    rdx(CODE_CMDWORD);
    chk(rd, 16'h0000);
    wr(CODE_CMDWORD, 16'h0000, 1'b0);
    wr(CODE_STORE, 16'h0001, 1'b0);
    chk(storeBusy, 1'b1);
    for (int i = 0; i < 20 && storeBusy; i++) tick(1);
    chk(storeBusy, 1'b0);
  endtask
  task automatic t_misc;
    ctlIn.trimPlus = 1;
    tick(2);
    chk(cmdOut.trimPlus, 1'b1);
    ctlIn.trimPlus = 0;
    indexOk = 1;
    auxOut = 2'b10;
    tick(2);
    chk(cmdOut.trimPlus, 1'b0);
    rdx(CODE_STATUS);
    chk(rd, 16'h000a);
    wr(CODE_DEADBAND, 16'd401, 1'b1);
    wr(CODE_OFFSET, 16'd201, 1'b1);
  endtask
  task automatic chk_dir(input logic f, input logic r, input logic [11:0] d);
    tick(3);
    chk(ctlOut[2], f);
    chk(ctlOut[3], r);
    chk(dacOut, d);
  endtask
  task automatic t_quad;
    ctlIn.reset = 1;
    masterMoving = 1;
    speedRef = 12'sd100;
    for (int s = 5; s < 7; s++) begin
      wr(CODE_FFSEL, 16'(s), 1'b0);
      chk_dir(1'b1, 1'b0, 12'd100);
    end
    wr(CODE_FFSEL, 16'h0007, 1'b1);
    masterReverse = 1;
    speedRef = -12'sd100;
    chk_dir(1'b0, 1'b1, 12'd100);
    masterReverse = 0;
    speedRef = 12'sd100;
    wr(CODE_OFFSET, 16'hffec, 1'b0);
    chk_dir(1'b1, 1'b0, 12'd120);
    wr(CODE_OFFSET, 16'h0000, 1'b0);
    wr(CODE_DEADBAND, 16'd400, 1'b0);
    tick(3);
    chk(ctlOut[3:2], 2'b00);
    wr(CODE_DEADBAND, 16'h0000, 1'b0);
    masterMoving = 0;
    chk_dir(1'b0, 1'b0, 12'd0);
    ctlIn.reset = 0;
    errInc = 1;
    tick(3);
    errInc = 0;
    chk_dir(1'b1, 1'b0, CREEP_REF);
    errDec = 1;
    tick(6);
    errDec = 0;
    chk_dir(1'b0, 1'b1, CREEP_REF);
  endtask
  // long increment run drives the error memory into its limit
  task automatic t_sat;
    masterMoving = 1;
    errInc = 1;
    tick(32010);
    errInc = 0;
    tick(1);
    chk(errCount, 16'd32000);
    chk_dir(1'b1, 1'b0, 12'd611);
  endtask

  initial begin
    {reqValid, reqWrite, errInc, errDec, masterMoving, masterReverse} = '0;
    {outOfSync, indexOk, auxOut, reqCode, reqData, speedRef} = '0;
    ctlIn = '0;
    t_boot(EE_LOAD, 16'h000f);
    ctlIn = 6'h3f;
    t_boot(EE_ERASE, 16'(PARAM_DEFAULT.deadBand));
    ctlIn = '0;
    t_cmd;
    t_misc;
    t_quad;
    t_sat;
    wrap_up;
  end
endmodule

// ===== verification/sync_ctrl_props.sv
/*
 Port-level checks of the command and output block.
 Assumes one request per reqValid pulse and a single clock domain.
*/
`timescale 1ns/1ps
module sync_ctrl_props
  import sync_ctrl_pkg::*;
(
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               reset,
  // serial port
  input wire logic               reqValid,
  input wire logic               reqWrite,
  input wire logic [7:0]         reqCode,
  input wire logic [15:0]        reqData,
  input wire logic               rspValid,
  input wire logic               rspErr,
  input wire logic [15:0]        rspData,
  // commands and eeprom
  input wire ctl_t               ctlIn,
  input wire ctl_t               cmdOut,
  input wire logic signed [15:0] errCount,
  input wire logic               eeReq,
  input wire ee_op_t             eeOp,
  input wire logic               eeDone,
  input wire logic               ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_eeAck; eeReq && eeDone; endsequence
  sequence s_rdCmd; reqValid && !reqWrite && reqCode == CODE_CMDWORD; endsequence

  property p_rsp; reqValid |=> rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer to request");
  property p_mask; s_rdCmd |=> (rspData & ~CMD_MASK) == 16'h0000; endproperty
  a_mask: assert property (p_mask) else $error("spare command bits set");
  property p_range;
    reqValid && reqWrite && reqCode == CODE_DEADBAND && reqData > 16'h0190 |=> rspErr;
  endproperty
  a_range: assert property (p_range) else $error("dead band over range taken");
  property p_orHw; ctlIn.trimPlus |=> cmdOut.trimPlus; endproperty
  a_orHw: assert property (p_orHw) else $error("input not in command");
  property p_rstHold; ctlIn.reset [*3] |-> errCount == 16'sh0000; endproperty
  a_rstHold: assert property (p_rstHold) else $error("error count not held");
  property p_sat; errCount <= ERR_SAT && errCount >= -ERR_SAT; endproperty
  a_sat: assert property (p_sat) else $error("error memory past limit");
  // all six inputs high at release picks erase over load
  property p_boot;
    $fell(reset) |=> eeReq && eeOp == ($past(ctlIn) == 6'h3f ? EE_ERASE : EE_LOAD);
  endproperty
  a_boot: assert property (p_boot) else $error("wrong power-up request");
  property p_eeAck; s_eeAck |=> !eeReq; endproperty
  a_eeAck: assert property (p_eeAck) else $error("request kept after done");
  property p_rdy; $rose(ready) |-> $past(eeDone); endproperty
  a_rdy: assert property (p_rdy) else $error("ready without eeprom done");
endmodule

bind sync_controller_command_outputs sync_ctrl_props i_props (
  .clk_sys, .reset, .reqValid, .reqWrite, .reqCode, .reqData, .rspValid, .rspErr,
  .rspData, .ctlIn, .cmdOut, .errCount, .eeReq, .eeOp, .eeDone, .ready
);
